/* File: include/flash_spm_pkg.sv */
package flash_spm_pkg;
   // Clock and programming time
   localparam int CLK_MHZ = 250;
   localparam real PROG_MIN_MS = 3.7;
   localparam real PROG_MAX_MS = 4.5;
   // Least time rounds up, longest rounds down
   localparam int PROG_MIN_CYC = int'($ceil(PROG_MIN_MS * 1000.0 * CLK_MHZ));
   localparam int PROG_MAX_CYC = int'($floor(PROG_MAX_MS * 1000.0 * CLK_MHZ));
   // Instruction windows after a control write, in cycles
   localparam logic [2:0] SPM_WIN = 3'h4;
   localparam logic [2:0] LPM_WIN = 3'h3;
   // Register map (printed offset is an index; byte address is four times it)
   localparam int AXI_AW = 12;
   localparam logic [7:0] CTRL_IDX = 8'h37;
   localparam logic [AXI_AW-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Control register fields
   localparam int BIT_IE = 7;
   localparam int BIT_SIG = 5;
   localparam int BIT_CLR = 4;
   localparam int BIT_LFR = 3;
   localparam int BIT_PW = 2;
   localparam int BIT_PE = 1;
   localparam int BIT_EN = 0;
   // Command patterns in bits 5:0
   localparam logic [5:0] CMD_LOAD = 6'h01;
   localparam logic [5:0] CMD_ERASE = 6'h03;
   localparam logic [5:0] CMD_WRITE = 6'h05;
   localparam logic [5:0] CMD_LFREAD = 6'h09;
   // Pointer values for lock and fuse reads
   localparam int PTR_W = 16;
   localparam logic [PTR_W-1:0] Z_FUSE_LOW = 16'h0000;
   localparam logic [PTR_W-1:0] Z_LOCK = 16'h0001;
   localparam logic [PTR_W-1:0] Z_FUSE_EXT = 16'h0002;
   localparam logic [PTR_W-1:0] Z_FUSE_HIGH = 16'h0003;
   localparam int WORD_W = 16;
   localparam int PAGE_WORDS = 32;
   localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ARMED = 4'h2,
      ST_ERASE = 4'h4,
      ST_WRITE = 4'h8
   } seq_state_t;
endpackage : flash_spm_pkg

/* File: hw/op_timer.sv */
`timescale 1ns/1ns
module op_timer #(
   parameter int CYCLES = 925000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);
   typedef struct packed {
      logic busy;
      logic done;
      logic [CW-1:0] cnt;
   } tmr_t;
   tmr_t s_r, s_nxt;

   // Count down; done is a single-cycle pulse at the end
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (start && !s_r.busy) begin
         s_nxt.busy = 1'b1;
         s_nxt.cnt = CW'(CYCLES - 1);
      end else if (s_r.busy) begin
         if (s_r.cnt == '0) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt - CW'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;
   assign done = s_r.done;
endmodule : op_timer

/* File: hw/page_buf.sv */
`timescale 1ns/1ns
module page_buf #(
   parameter int WORDS = 32,
   parameter int W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr,
   input wire logic [$clog2(WORDS)-1:0] wr_idx,
   input wire logic [W-1:0] wr_data,
   input wire logic clr,
   input wire logic [$clog2(WORDS)-1:0] rd_idx,
   output logic [W-1:0] rd_word,
   output logic any_loaded
);
   import flash_spm_pkg::*;
   typedef struct packed {
      logic [WORDS-1:0][W-1:0] mem;
      logic [WORDS-1:0] loaded;
      logic [W-1:0] rd_word;
   } buf_t;
   buf_t s_r, s_nxt;

   // Unloaded slots read as erased flash so a partial page programs cleanly
   always_comb begin
      s_nxt = s_r;
      s_nxt.rd_word = s_r.loaded[rd_idx] ? s_r.mem[rd_idx] : ERASED_WORD;
      if (clr) begin
         s_nxt.loaded = '0;
      end
      // A load in the clearing cycle survives, so the set wins
      if (wr && (clr || !s_r.loaded[wr_idx])) begin
         // A second write to a filled slot is dropped
         s_nxt.mem[wr_idx] = wr_data;
         s_nxt.loaded[wr_idx] = 1'b1;
      end
   end

   // Reset empties the buffer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_word = s_r.rd_word;
   assign any_loaded = |s_r.loaded;
endmodule : page_buf

/* File: hw/flash_self_program_sequencer.sv */
`timescale 1ns/1ns
module flash_self_program_sequencer
   import flash_spm_pkg::*;
#(
   parameter int PROG_CYCLES = flash_spm_pkg::PROG_MIN_CYC,
   parameter int PAGE_WORDS = flash_spm_pkg::PAGE_WORDS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [flash_spm_pkg::AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [flash_spm_pkg::AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic spm_stb,
   input wire logic lpm_stb,
   input wire logic [flash_spm_pkg::PTR_W-1:0] z_ptr,
   input wire logic [flash_spm_pkg::WORD_W-1:0] word_data_pair,
   input wire logic gie,
   input wire logic eeprom_write_busy_bit,
   input wire logic [7:0] fuse_low_prog,
   input wire logic [7:0] fuse_high_prog,
   input wire logic [7:0] fuse_ext_prog,
   input wire logic [7:0] lock_prog,
   output logic cpu_stall,
   output logic [7:0] lpm_data,
   output logic lpm_valid,
   output logic prog_ready_irq,
   output logic [flash_spm_pkg::PTR_W-1:0] flash_rd_addr,
   input wire logic [flash_spm_pkg::WORD_W-1:0] flash_rd_word,
   output logic flash_erase,
   output logic flash_write,
   output logic [flash_spm_pkg::PTR_W-1:0] flash_page,
   output logic flash_wr_stb,
   output logic [$clog2(PAGE_WORDS)-1:0] flash_wr_idx,
   output logic [flash_spm_pkg::WORD_W-1:0] flash_wr_word
);
   import flash_spm_pkg::*;
   localparam int WB = $clog2(PAGE_WORDS);

   typedef struct packed {
      seq_state_t st;
      logic [7:0] ctrl;
      logic [2:0] elapsed;
      logic [PTR_W-1:0] page;
      logic streaming;
      logic [WB-1:0] sidx;
      logic flash_erase;
      logic flash_write;
      logic flash_wr_stb;
      logic [WB-1:0] flash_wr_idx;
      logic cpu_stall;
      logic lpm_pend;
      logic lpm_hi;
      logic lpm_valid;
      logic [7:0] lpm_data;
      logic [PTR_W-1:0] rd_addr;
      logic irq;
      logic aw_rdy;
      logic aw_got;
      logic [AXI_AW-1:0] awaddr;
      logic w_rdy;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   localparam state_t S_RST = '{st: ST_IDLE, ctrl: CTRL_RST, default: '0};

   state_t s_r, s_nxt;
   logic buf_wr, buf_clr, tmr_start, tmr_done, buf_any;
   logic lf_armed;

   // Page field only; word bits and byte bit forced to zero
   function automatic logic [PTR_W-1:0] page_base(input logic [PTR_W-1:0] z);
      page_base = z & ~((PTR_W'(1) << (WB + 1)) - PTR_W'(1));
   endfunction : page_base

   // Lock and fuse bytes; programmed bits read back as zero
   function automatic logic [7:0] fuse_sel(input logic [PTR_W-1:0] z);
      case (z)
         Z_FUSE_LOW: fuse_sel = ~fuse_low_prog;
         Z_LOCK: fuse_sel = ~lock_prog;
         Z_FUSE_EXT: fuse_sel = ~fuse_ext_prog;
         Z_FUSE_HIGH: fuse_sel = ~fuse_high_prog;
         default: fuse_sel = 8'hff;
      endcase
   endfunction : fuse_sel

   // Shared programming timer for erase and write
   op_timer #(.CYCLES(PROG_CYCLES)) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(tmr_start),
      .busy(),
      .done(tmr_done)
   );

   // Temporary page buffer, read back one slot per cycle during a write
   page_buf #(.WORDS(PAGE_WORDS), .W(WORD_W)) u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr(buf_wr),
      .wr_idx(z_ptr[WB:1]),
      .wr_data(word_data_pair),
      .clr(buf_clr),
      .rd_idx(s_r.sidx),
      .rd_word(flash_wr_word),
      .any_loaded(buf_any)
   );

   assign lf_armed = (s_r.st == ST_ARMED) && (s_r.ctrl[5:0] == CMD_LFREAD);

   // Bus slave, timed sequence and operation control
   always_comb begin
      s_nxt = s_r;
      buf_wr = 1'b0;
      buf_clr = 1'b0;
      tmr_start = 1'b0;
      s_nxt.lpm_valid = 1'b0;
      s_nxt.flash_wr_stb = 1'b0;
      s_nxt.lpm_pend = 1'b0;
      if (s_r.aw_rdy && awvalid) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = awaddr;
      end
      if (s_r.w_rdy && wvalid) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = wdata;
         s_nxt.wstrb = wstrb;
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_r.ar_rdy && arvalid) begin
         s_nxt.rvalid = 1'b1;
         if (araddr == CTRL_ADDR) begin
            s_nxt.rdata = {24'h0, s_r.ctrl};
            s_nxt.rresp = RESP_OKAY;
         end else begin
            s_nxt.rdata = 32'h0;
            s_nxt.rresp = RESP_SLVERR;
         end
      end
      // Timed window; the store is taken from any address
      case (s_r.st)
         ST_ARMED: begin
            s_nxt.elapsed = s_r.elapsed + 3'h1;
            if (spm_stb && s_r.elapsed < SPM_WIN) begin
               case (s_r.ctrl[5:0])
                  CMD_LOAD: begin
                     buf_wr = 1'b1;
                     s_nxt.ctrl[5:0] = 6'h0;
                     s_nxt.st = ST_IDLE;
                  end
                  CMD_ERASE: begin
                     s_nxt.page = page_base(z_ptr);
                     s_nxt.st = ST_ERASE;
                     s_nxt.flash_erase = 1'b1;
                     s_nxt.cpu_stall = 1'b1;
                     tmr_start = 1'b1;
                  end
                  CMD_WRITE: begin
                     s_nxt.page = page_base(z_ptr);
                     s_nxt.st = ST_WRITE;
                     s_nxt.flash_write = 1'b1;
                     s_nxt.cpu_stall = 1'b1;
                     s_nxt.streaming = 1'b1;
                     s_nxt.sidx = '0;
                     tmr_start = 1'b1;
                  end
                  default: begin
                     // Store during a read or clear sequence does nothing
                     s_nxt.ctrl[5:0] = 6'h0;
                     s_nxt.st = ST_IDLE;
                  end
               endcase
            end else if (lpm_stb && lf_armed && s_r.elapsed < LPM_WIN) begin
               s_nxt.lpm_valid = 1'b1;
               s_nxt.lpm_data = fuse_sel(z_ptr);
               s_nxt.ctrl[5:0] = 6'h0;
               s_nxt.st = ST_IDLE;
            end else if (s_r.elapsed == (lf_armed ? LPM_WIN - 3'h1 : SPM_WIN - 3'h1)) begin
               s_nxt.ctrl[5:0] = 6'h0;
               s_nxt.st = ST_IDLE;
            end
         end
         ST_ERASE, ST_WRITE: begin
            if (s_r.streaming) begin
               s_nxt.flash_wr_stb = 1'b1;
               s_nxt.flash_wr_idx = s_r.sidx;
               s_nxt.sidx = s_r.sidx + WB'(1);
               if (s_r.sidx == WB'(PAGE_WORDS - 1)) begin
                  s_nxt.streaming = 1'b0;
               end
            end
            // Enable bit held until the timer ends, so software can poll it
            if (tmr_done) begin
               s_nxt.st = ST_IDLE;
               s_nxt.ctrl[5:0] = 6'h0;
               s_nxt.cpu_stall = 1'b0;
               s_nxt.flash_erase = 1'b0;
               s_nxt.flash_write = 1'b0;
               if (s_r.st == ST_WRITE) begin
                  buf_clr = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      // Ordinary byte read of flash when no lock or fuse read is armed
      if (lpm_stb && !lf_armed && !s_r.cpu_stall) begin
         s_nxt.rd_addr = z_ptr;
         s_nxt.lpm_pend = 1'b1;
         s_nxt.lpm_hi = z_ptr[0];
      end
      if (s_r.lpm_pend) begin
         s_nxt.lpm_valid = 1'b1;
         s_nxt.lpm_data = s_r.lpm_hi ? flash_rd_word[15:8] : flash_rd_word[7:0];
      end
      // Register write; commands refused while EEPROM busy or operation running
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bresp = (s_r.awaddr == CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
         if (s_r.awaddr == CTRL_ADDR && s_r.wstrb[0]) begin
            s_nxt.ctrl[BIT_IE] = s_r.wdata[BIT_IE];
            if (!eeprom_write_busy_bit && s_r.wdata[BIT_EN] &&
                (s_nxt.st == ST_IDLE || s_nxt.st == ST_ARMED)) begin
               s_nxt.ctrl[5:0] = s_r.wdata[5:0];
               s_nxt.st = ST_ARMED;
               s_nxt.elapsed = 3'h0;
               if (s_r.wdata[BIT_CLR]) begin
                  buf_clr = 1'b1;
               end
            end
         end
      end
      // EEPROM write loses partially loaded data
      if (eeprom_write_busy_bit && buf_any && s_r.st != ST_WRITE) begin
         buf_clr = 1'b1;
      end
      s_nxt.irq = s_nxt.ctrl[BIT_IE] && gie && !s_nxt.ctrl[BIT_EN] &&
                  !eeprom_write_busy_bit && !s_nxt.cpu_stall;
      s_nxt.aw_rdy = !s_nxt.aw_got;
      s_nxt.w_rdy = !s_nxt.w_got;
      s_nxt.ar_rdy = !s_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= S_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign awready = s_r.aw_rdy;
   assign wready = s_r.w_rdy;
   assign bresp = s_r.bresp;
   assign bvalid = s_r.bvalid;
   assign arready = s_r.ar_rdy;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;
   assign rvalid = s_r.rvalid;
   assign cpu_stall = s_r.cpu_stall;
   assign lpm_data = s_r.lpm_data;
   assign lpm_valid = s_r.lpm_valid;
   assign prog_ready_irq = s_r.irq;
   assign flash_rd_addr = s_r.rd_addr;
   assign flash_erase = s_r.flash_erase;
   assign flash_write = s_r.flash_write;
   assign flash_page = s_r.page;
   assign flash_wr_stb = s_r.flash_wr_stb;
   assign flash_wr_idx = s_r.flash_wr_idx;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Checks
   AST_ERASE_START: assert property (
      (s_r.st == ST_ARMED && s_r.ctrl[5:0] == CMD_ERASE && spm_stb && s_r.elapsed < SPM_WIN)
      |=> flash_erase && cpu_stall && flash_page == page_base($past(z_ptr)))
      else $error("erase did not start on timed store");
   AST_STALL_OP: assert property (
      (flash_erase || flash_write) |-> cpu_stall)
      else $error("cpu not stalled during operation");
   AST_WINDOW_LAPSE: assert property (
      (s_r.st == ST_ARMED && !lf_armed && s_r.elapsed == SPM_WIN - 3'h1 && !spm_stb
       && !(s_r.aw_got && s_r.w_got && !s_r.bvalid))
      |=> s_r.ctrl[5:0] == 6'h0 && !flash_erase && !flash_write)
      else $error("command bits survived missed window");
   AST_EN_HELD: assert property (
      (flash_erase || flash_write) |-> s_r.ctrl[BIT_EN])
      else $error("enable bit dropped during operation");
   AST_EE_BLOCK: assert property (
      (s_r.st == ST_IDLE && eeprom_write_busy_bit) |=> s_r.st != ST_ARMED)
      else $error("command armed while EEPROM busy");
   AST_LOCK_READ: assert property (
      (lf_armed && lpm_stb && z_ptr == Z_LOCK && s_r.elapsed < LPM_WIN)
      |=> lpm_valid && lpm_data == ~$past(lock_prog) && s_r.ctrl[BIT_EN] == 1'b0)
      else $error("lock byte not returned");
   AST_IRQ_GATE: assert property (
      prog_ready_irq |-> !s_r.ctrl[BIT_EN] && !cpu_stall && $past(gie))
      else $error("ready interrupt while busy");
   AST_BUF_AFTER_WRITE: assert property (
      $fell(flash_write) |-> !buf_any)
      else $error("page buffer not cleared after write");
   AST_LPM_BYTE: assert property (
      (lpm_stb && !lf_armed && !cpu_stall) |=> ##1
      lpm_valid && lpm_data == ($past(z_ptr[0], 2) ? $past(flash_rd_word[15:8])
                                                   : $past(flash_rd_word[7:0])))
      else $error("byte select wrong on flash read");
   AST_OP_LEN: assert property (
      $rose(cpu_stall) |-> cpu_stall [*8])
      else $error("operation ended too soon");
   COV_ERASE: cover property ($rose(flash_erase));
   COV_WRITE: cover property ($fell(flash_write));
   COV_LOAD: cover property (buf_wr);
   COV_FUSE: cover property (lf_armed && lpm_stb && s_r.elapsed < LPM_WIN);
endmodule : flash_self_program_sequencer

/* File: sim/flash_array_model.sv */
`timescale 1ns/1ns
// Flash array behind the sequencer; read is combinational on the registered address
module flash_array_model #(
   parameter int PAGE_WORDS = 32
) (
   input wire logic aclk,
   input wire logic [15:0] flash_rd_addr,
   output logic [15:0] flash_rd_word,
   input wire logic flash_erase,
   input wire logic [15:0] flash_page,
   input wire logic flash_wr_stb,
   input wire logic [$clog2(PAGE_WORDS)-1:0] flash_wr_idx,
   input wire logic [15:0] flash_wr_word
);
   localparam int LW = $clog2(PAGE_WORDS);
   logic [15:0] mem [0:1023];
   logic erase_q;
   // Blank array, so unwritten words read back as erased
   initial begin
      erase_q = 1'b0;
      for (int i = 0; i < 1024; i++) begin
         mem[i] = 16'hffff;
      end
   end
   assign flash_rd_word = mem[flash_rd_addr[10:1]];
   // Erase once per request, streamed words land one a cycle
   always @(posedge aclk) begin
      erase_q <= flash_erase;
      if (flash_erase && !erase_q) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            mem[{flash_page[10:LW+1], LW'(i)}] <= 16'hffff;
         end
      end
      if (flash_wr_stb) begin
         mem[{flash_page[10:LW+1], flash_wr_idx}] <= flash_wr_word;
      end
   end
endmodule : flash_array_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import flash_spm_pkg::*;
   localparam int PROG = 40;
   localparam logic [15:0] P = 16'h0140;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
   logic awready, wready, arready, spm_stb, lpm_stb, gie, ee_busy, cpu_stall;
   logic lpm_valid, prog_ready_irq, flash_erase, flash_write, flash_wr_stb;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [15:0] z_ptr, wdp, flash_rd_addr, flash_rd_word, flash_page, flash_wr_word;
   logic [7:0] lpm_data, f_lo, f_hi, f_ex, f_lk, b;
   logic [4:0] flash_wr_idx;
   logic [31:0] d;
   logic [7:0] pats [4] = '{8'h09, 8'h01, 8'h03, 8'h05};
   logic [15:0] rz [5] = '{16'h0140, 16'h0141, 16'h017e, 16'h017f, 16'h0142};
   logic [7:0] rv [5] = '{8'h34, 8'h12, 8'hcd, 8'hab, 8'hff};
   logic [7:0] fexp [4];
   int err_total, n_checks;

   flash_self_program_sequencer #(.PROG_CYCLES(PROG), .PAGE_WORDS(32)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .spm_stb(spm_stb), .lpm_stb(lpm_stb), .z_ptr(z_ptr), .word_data_pair(wdp),
      .gie(gie), .eeprom_write_busy_bit(ee_busy), .fuse_low_prog(f_lo),
      .fuse_high_prog(f_hi), .fuse_ext_prog(f_ex), .lock_prog(f_lk),
      .cpu_stall(cpu_stall), .lpm_data(lpm_data), .lpm_valid(lpm_valid),
      .prog_ready_irq(prog_ready_irq), .flash_rd_addr(flash_rd_addr),
      .flash_rd_word(flash_rd_word), .flash_erase(flash_erase), .flash_write(flash_write),
      .flash_page(flash_page), .flash_wr_stb(flash_wr_stb), .flash_wr_idx(flash_wr_idx),
      .flash_wr_word(flash_wr_word));

   flash_array_model #(.PAGE_WORDS(32)) u_flash (
      .aclk(aclk), .flash_rd_addr(flash_rd_addr), .flash_rd_word(flash_rd_word),
      .flash_erase(flash_erase), .flash_page(flash_page), .flash_wr_stb(flash_wr_stb),
      .flash_wr_idx(flash_wr_idx), .flash_wr_word(flash_wr_word));

   // 250 MHz
   always #2 aclk = ~aclk;

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task results;
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   // Address and data offered together, each dropped once taken
   task axi_wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] resp);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
      // Let an edge pass so a following call never re-raises bready at once
      @(posedge aclk);
   endtask : axi_wr

   task axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   // Store follows the control write at once, as with interrupts masked
   task spm_cmd(input logic [7:0] c, input logic [15:0] z, input logic [15:0] w);
      axi_wr(CTRL_ADDR, c, r);
      z_ptr <= z;
      wdp <= w;
      spm_stb <= 1'b1;
      @(posedge aclk);
      spm_stb <= 1'b0;
   endtask : spm_cmd

   task lpm(input logic [15:0] z, output logic [7:0] v);
      int n;
      n = 0;
      z_ptr <= z;
      lpm_stb <= 1'b1;
      @(posedge aclk);
      lpm_stb <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (lpm_valid !== 1'b1 && n < 8);
      v = lpm_data;
   endtask : lpm

   // Erase or write, stall length counted from the ports
   task prog_op(input logic [7:0] c, input logic [15:0] z);
      int n;
      n = 0;
      spm_cmd(8'h80 | c, z, 16'h0f0f);
      @(posedge aclk);
      check(cpu_stall, 1'b1);
      check(flash_page, z & 16'hffc0);
      check({flash_erase, flash_write}, (c == 8'h03) ? 2'b10 : 2'b01);
      check(prog_ready_irq, 1'b0);
      while (cpu_stall === 1'b1 && n < 1000) begin
         n++;
         @(posedge aclk);
      end
      check(32'(n), PROG + 1);
      axi_rd(CTRL_ADDR, d, r);
      check(d, 32'h80);
   endtask : prog_op

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      results();
   end

   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, spm_stb, lpm_stb} = '0;
      {awaddr, araddr, wdata, wstrb, z_ptr, wdp, ee_busy} = '0;
      gie = 1'b1;
      {f_lo, f_hi, f_ex, f_lk} = {8'h9c, 8'h26, 8'h01, 8'h03};
      fexp = '{~8'h9c, ~8'h03, ~8'h01, ~8'h26};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_rd(CTRL_ADDR, d, r);
      check(d, CTRL_RST);
      axi_rd(12'h000, d, r);
      check(r, RESP_SLVERR);
      // Lock and fuse bytes, inverted on return
      for (int i = 0; i < 4; i++) begin
         axi_wr(CTRL_ADDR, 8'h09, r);
         lpm(16'(i), b);
         check(b, fexp[i]);
      end
      // No instruction in the window: command bits drop
      for (int i = 0; i < 4; i++) begin
         axi_wr(CTRL_ADDR, pats[i], r);
         repeat (6) @(posedge aclk);
         axi_rd(CTRL_ADDR, d, r);
         check(d, 32'h0);
         check(cpu_stall, 1'b0);
      end
      axi_wr(CTRL_ADDR, 8'h80, r);
      repeat (2) @(posedge aclk);
      check(prog_ready_irq, 1'b1);
      gie <= 1'b0;
      repeat (2) @(posedge aclk);
      check(prog_ready_irq, 1'b0);
      gie <= 1'b1;
      repeat (2) @(posedge aclk);
      // Fill two slots once each, erase, write the same page
      spm_cmd(8'h81, P, 16'h1234);
      spm_cmd(8'h81, P | 16'h003e, 16'habcd);
      prog_op(8'h03, P | 16'h003f);
      prog_op(8'h05, P);
      for (int i = 0; i < 5; i++) begin
         lpm(rz[i], b);
         check(b, rv[i]);
      end
      // Clear bit, then an EEPROM write in mid-load
      spm_cmd(8'h81, P, 16'h5a5a);
      axi_wr(CTRL_ADDR, 8'h91, r);
      repeat (5) @(posedge aclk);
      spm_cmd(8'h81, P | 16'h0002, 16'h6b6b);
      ee_busy <= 1'b1;
      @(posedge aclk);
      ee_busy <= 1'b0;
      @(posedge aclk);
      spm_cmd(8'h81, P | 16'h0004, 16'h7c7c);
      prog_op(8'h03, P);
      prog_op(8'h05, P);
      lpm(P, b);
      check(b, 8'hff);
      lpm(P | 16'h0002, b);
      check(b, 8'hff);
      lpm(P | 16'h0004, b);
      check(b, 8'h7c);
      prog_op(8'h05, P);
      lpm(P | 16'h0004, b);
      check(b, 8'hff);
      // Busy EEPROM locks out programming
      ee_busy <= 1'b1;
      spm_cmd(8'h83, P, 16'h0);
      repeat (3) @(posedge aclk);
      check(cpu_stall, 1'b0);
      axi_rd(CTRL_ADDR, d, r);
      check(d[5:0], 6'h0);
      ee_busy <= 1'b0;
      results();
   end
endmodule : tb_top
